// file: verilog/hpp_defs.svh
`ifndef HPP_DEFS_SVH
`define HPP_DEFS_SVH

// Register byte offsets (low address byte decoded)
`define HPP_OFF_CTRL 8'h00
`define HPP_OFF_GPIO_EN 8'h04
`define HPP_OFF_GPIO_DIR 8'h08
`define HPP_OFF_GPIO_OUT 8'h0c
`define HPP_OFF_GPIO_IN 8'h10
`define HPP_OFF_TX_DATA 8'h14
`define HPP_OFF_RX_DATA 8'h18
`define HPP_OFF_STATUS 8'h1c

// Control register field positions
`define HPP_CTRL_HOST_FN 0
`define HPP_CTRL_MUX_BUS 1
`define HPP_CTRL_DBL_STROBE 2
`define HPP_CTRL_DBL_REQ 3
`define HPP_CTRL_AS_HI 4
`define HPP_CTRL_DS_HI 5
`define HPP_CTRL_WR_HI 6
`define HPP_CTRL_CS_HI 7
`define HPP_CTRL_REQ_HI 8
`define HPP_CTRL_RRQ_HI 9
`define HPP_CTRL_ACK_HI 10
`define HPP_CTRL_OPEN_DRAIN 11
`define HPP_CTRL_W 12

// Status register field positions
`define HPP_STAT_TX_FULL 0
`define HPP_STAT_RX_FULL 1
`define HPP_STAT_ADDR_LSB 8
`define HPP_ADDR_W 11

// Reset values: GPIO disconnected, all polarities active low
`define HPP_CTRL_RST 12'h000
`define HPP_GPIO_RST 16'h0000
`define HPP_PINS 16

`endif

// file: verilog/hpp_pkg.sv
`default_nettype none
package hpp_pkg;

  // Host port configuration, bit 11 first, bit 0 last at the bottom
  typedef struct packed {
    logic open_drain;
    logic ack_hi;
    logic rrq_hi;
    logic req_hi;
    logic cs_hi;
    logic wr_hi;
    logic ds_hi;
    logic as_hi;
    logic dbl_req;
    logic dbl_strobe;
    logic mux_bus;
    logic host_fn;
  } hpp_ctrl_s;

  // Captured AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } hpp_ahb_req_s;

  // Phase of a host access on the pins
  typedef enum logic [1:0] {
    HP_IDLE,
    HP_READ,
    HP_WRITE
  } hpp_phase_e;

endpackage
`default_nettype wire

// file: verilog/hpp_req_drv.sv
`timescale 1ns/1ps
`default_nettype none
// Request pin driver: polarity then driven or open-drain output
module hpp_req_drv
  import hpp_pkg::*;
(
  input wire logic active,
  input wire logic act_hi,
  input wire logic open_drain,
  output logic pin_val,
  output logic pin_en
);

  // Open drain only pulls low; a high level is left to the pull-up
  always_comb begin
    pin_val = ~(active ^ act_hi);
    pin_en = open_drain ? ~pin_val : 1'b1;
  end

endmodule
`default_nettype wire

// file: verilog/hpp_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
// One port pin: host function or general-purpose I/O, never both
module hpp_pin_cell
  import hpp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic host_sel,
  input wire logic host_out,
  input wire logic host_en,
  input wire logic gpio_en,
  input wire logic gpio_dir,
  input wire logic gpio_out,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe_n,
  output logic gpio_in
);

  logic drive;

  assign drive = host_sel ? host_en : (gpio_en & gpio_dir);

  // Registered pad drive; released after reset (disconnected)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_out <= 1'b0;
      pad_oe_n <= 1'b1;
    end else begin
      pad_out <= host_sel ? host_out : gpio_out;
      pad_oe_n <= ~drive;
    end
  end

  // Disconnected or host-owned pins are not sampled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpio_in <= 1'b0;
    end else begin
      gpio_in <= (~host_sel & gpio_en & ~gpio_dir) ? pad_in : 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: verilog/hpp_top.sv
// Contract
// - Byte-wide two-way data path to a host bus, no glue logic.
// - Non-multiplexed host mode: pins 0-7 are tri-state data lines.
// - Multiplexed host mode: pins 0-7 carry address and data, time-shared.
// - GPIO mode: each pin set as input, output or disconnected.
// - After reset every pin is GPIO disconnected, neither driving nor sampling.
// - Multiplexed: address strobe input, polarity set, active low after reset.
// - Single strobe: one data strobe input, polarity set, active low.
// - Double strobe: read and write strobes, each polarity set, active low.
// - Non-multiplexed: chip-select input, polarity set, active low.
// - Single request: one request output, polarity set, active low.
// - Single request: acknowledge input, polarity set, active low.
// - Double request: transmit and receive requests, each polarity set.
// - Each request output may be driven or open-drain.
`include "hpp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module hpp_top
  import hpp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] pad_in,
  output logic [15:0] pad_out,
  output logic [15:0] pad_oe_n
);

  // Bus-side state: configuration, captured request, host phase
  hpp_ctrl_s ctrl_q;
  hpp_ahb_req_s req_q;
  hpp_phase_e phase_q;
  hpp_phase_e phase_d;

  // General-purpose I/O registers and the sampled pin levels
  logic [15:0] gpio_en_q;
  logic [15:0] gpio_dir_q;
  logic [15:0] gpio_out_q;
  logic [15:0] gpio_in;

  // One byte buffered each way, with its full flag
  logic [7:0] tx_data_q;
  logic [7:0] rx_data_q;
  logic tx_full_q;
  logic rx_full_q;

  // Address latching and the last host address for software
  logic as_prev_q;
  logic [`HPP_ADDR_W-1:0] mux_addr_q;
  logic [`HPP_ADDR_W-1:0] last_addr_q;
  logic [`HPP_ADDR_W-1:0] cur_addr;

  // Single-cycle strobes from the bus and from the host pins
  logic addr_phase;
  logic sw_tx_wr;
  logic sw_rx_rd;
  logic host_wr_start;
  logic host_rd_end;

  // Host controls after polarity; high means asserted
  logic as_act;
  logic ds_act;
  logic rd_act;
  logic wr_act;
  logic cs_act;
  logic ack_act;
  logic sel_act;
  logic rd_cyc;
  logic wr_cyc;

  // Request drivers, host pin roles and the read mux
  logic req14_val;
  logic req14_en;
  logic req15_val;
  logic req15_en;
  logic [15:0] host_out;
  logic [15:0] host_en;
  logic [31:0] rd_val;

  // AHB address phase accepted only on a valid transfer with hready high
  // hsize is ignored: every register is one aligned whole word
  assign addr_phase = hsel & htrans[1] & hready;

  // Capture address phase; writes complete in the following data phase
  // Upper address bits are not decoded, so the map repeats every 256 bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else if (hready) begin
      req_q.valid <= addr_phase;
      req_q.write <= hwrite;
      req_q.addr <= haddr[7:0];
    end
  end

  // Zero wait states and always OKAY, so both answers are constants
  // Nothing here can stall, so a wait state would only cost bandwidth
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign sw_tx_wr = req_q.valid & req_q.write &
                    (req_q.addr == `HPP_OFF_TX_DATA);
  assign sw_rx_rd = addr_phase & ~hwrite &
                    (haddr[7:0] == `HPP_OFF_RX_DATA);

  // Read mux; unmapped offsets read as zero
  // The receive pop is decoded apart from this mux, which has no side effect
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (haddr[7:0])
      `HPP_OFF_CTRL: rd_val[`HPP_CTRL_W-1:0] = ctrl_q;
      `HPP_OFF_GPIO_EN: rd_val[15:0] = gpio_en_q;
      `HPP_OFF_GPIO_DIR: rd_val[15:0] = gpio_dir_q;
      `HPP_OFF_GPIO_OUT: rd_val[15:0] = gpio_out_q;
      `HPP_OFF_GPIO_IN: rd_val[15:0] = gpio_in;
      `HPP_OFF_TX_DATA: rd_val[7:0] = tx_data_q;
      `HPP_OFF_RX_DATA: rd_val[7:0] = rx_data_q;
      `HPP_OFF_STATUS: begin
        rd_val[`HPP_STAT_TX_FULL] = tx_full_q;
        rd_val[`HPP_STAT_RX_FULL] = rx_full_q;
        rd_val[`HPP_STAT_ADDR_LSB +: `HPP_ADDR_W] = last_addr_q;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Read data is fetched in the address phase so it stands in the data phase
  // It then holds until the next read, which eases a slow sampler
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase & ~hwrite) begin
      hrdata <= rd_val;
    end
  end

  // Configuration and GPIO registers
  // A new mode reaches the pins one cycle later through the pin cells
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `HPP_CTRL_RST;
      gpio_en_q <= `HPP_GPIO_RST;
      gpio_dir_q <= `HPP_GPIO_RST;
      gpio_out_q <= `HPP_GPIO_RST;
    end else if (req_q.valid & req_q.write) begin
      unique case (req_q.addr)
        `HPP_OFF_CTRL: ctrl_q <= hpp_ctrl_s'(hwdata[`HPP_CTRL_W-1:0]);
        `HPP_OFF_GPIO_EN: gpio_en_q <= hwdata[15:0];
        `HPP_OFF_GPIO_DIR: gpio_dir_q <= hwdata[15:0];
        `HPP_OFF_GPIO_OUT: gpio_out_q <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // Host-side controls, each inverted by its polarity bit
  // Pins are taken as synchronous; an asynchronous host needs a synchroniser
  always_comb begin
    as_act = ~(pad_in[8] ^ ctrl_q.as_hi);
    ds_act = ~(pad_in[12] ^ ctrl_q.ds_hi);
    rd_act = ~(pad_in[11] ^ ctrl_q.ds_hi);
    wr_act = ~(pad_in[12] ^ ctrl_q.wr_hi);
    cs_act = ~(pad_in[13] ^ ctrl_q.cs_hi);
    ack_act = ~(pad_in[15] ^ ctrl_q.ack_hi);
  end

  // The multiplexed bus has no chip select; decoding is left to the host
  assign sel_act = ctrl_q.host_fn & (ctrl_q.mux_bus | cs_act);

  // Direction from read/write pin or from the two strobes
  // Read wins a clash so the host never sees the data lines floating
  always_comb begin
    if (ctrl_q.dbl_strobe) begin
      rd_cyc = sel_act & rd_act;
      wr_cyc = sel_act & wr_act;
    end else begin
      rd_cyc = sel_act & ds_act & pad_in[11];
      wr_cyc = sel_act & ds_act & ~pad_in[11];
    end
    // Acknowledge lets a DMA engine read without address or strobe
    if (ctrl_q.host_fn & ~ctrl_q.dbl_req & ack_act) begin
      rd_cyc = 1'b1;
    end
    if (rd_cyc & wr_cyc) begin
      wr_cyc = 1'b0;
    end
  end

  // Access address: latched from the shared lines or taken from pins 8-10
  // Only eight addresses are reachable without the multiplexed bus
  assign cur_addr = ctrl_q.mux_bus ? mux_addr_q :
                    {8'h00, pad_in[10], pad_in[9], pad_in[8]};

  // Multiplexed address latch on the strobe's leading edge
  // Edge detection stops a long strobe relatching a bus that moved on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      as_prev_q <= 1'b0;
      mux_addr_q <= '0;
    end else begin
      as_prev_q <= as_act & ctrl_q.host_fn & ctrl_q.mux_bus;
      if (ctrl_q.host_fn & ctrl_q.mux_bus & as_act & ~as_prev_q) begin
        mux_addr_q <= {pad_in[13], pad_in[10:9], pad_in[7:0]};
      end
    end
  end

  // Phase of the host access, used to find strobe edges
  // A strobe must span at least one rising clock edge or its edges may be lost
  always_comb begin
    if (rd_cyc) begin
      phase_d = HP_READ;
    end else if (wr_cyc) begin
      phase_d = HP_WRITE;
    end else begin
      phase_d = HP_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= HP_IDLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign host_wr_start = (phase_d == HP_WRITE) & (phase_q != HP_WRITE);
  assign host_rd_end = (phase_q == HP_READ) & (phase_d != HP_READ);

  // Record the address of every host access that starts from idle, for software
  // Taken at the start so the strobe's trailing edge cannot disturb it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_addr_q <= '0;
    end else if ((phase_d != HP_IDLE) & (phase_q == HP_IDLE)) begin
      last_addr_q <= cur_addr;
    end
  end

  // Byte from host; a new byte landing as software reads it keeps it full
  // A second host write before software reads overwrites the first byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_data_q <= 8'h00;
      rx_full_q <= 1'b0;
    end else if (host_wr_start) begin
      rx_data_q <= pad_in[7:0];
      rx_full_q <= 1'b1;
    end else if (sw_rx_rd) begin
      rx_full_q <= 1'b0;
    end
  end

  // Byte to host; emptied when the host's read strobe ends, set wins
  // Software may replace a byte that the host has not yet fetched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_data_q <= 8'h00;
      tx_full_q <= 1'b0;
    end else if (sw_tx_wr) begin
      tx_data_q <= hwdata[7:0];
      tx_full_q <= 1'b1;
    end else if (host_rd_end) begin
      tx_full_q <= 1'b0;
    end
  end

  // Pin 14 is the single request or the transmit request
  hpp_req_drv u_req14 (
    .active(tx_full_q),
    .act_hi(ctrl_q.req_hi),
    .open_drain(ctrl_q.open_drain),
    .pin_val(req14_val),
    .pin_en(req14_en)
  );

  // Pin 15 is the receive request when two requests are used
  // It asserts while the receive buffer is empty, inviting a host write
  hpp_req_drv u_req15 (
    .active(~rx_full_q),
    .act_hi(ctrl_q.rrq_hi),
    .open_drain(ctrl_q.open_drain),
    .pin_val(req15_val),
    .pin_en(req15_en)
  );

  // Host-function pin roles; pins 8-13 are always inputs in host mode
  // Data lines drive only during a read, so the two sides never fight
  always_comb begin
    host_out = 16'h0000;
    host_en = 16'h0000;
    host_out[7:0] = tx_data_q;
    host_en[7:0] = {8{rd_cyc}};
    host_out[14] = req14_val;
    host_en[14] = req14_en;
    host_out[15] = req15_val;
    host_en[15] = ctrl_q.dbl_req & req15_en;
  end

  // Sixteen pins, each owned by the host function or by GPIO
  // Each cell registers value and enable so every pad output is a flop
  genvar gi;
  generate
    for (gi = 0; gi < `HPP_PINS; gi = gi + 1) begin : g_pin
      hpp_pin_cell u_pin (
        .hclk(hclk),
        .hresetn(hresetn),
        .host_sel(ctrl_q.host_fn),
        .host_out(host_out[gi]),
        .host_en(host_en[gi]),
        .gpio_en(gpio_en_q[gi]),
        .gpio_dir(gpio_dir_q[gi]),
        .gpio_out(gpio_out_q[gi]),
        .pad_in(pad_in[gi]),
        .pad_out(pad_out[gi]),
        .pad_oe_n(pad_oe_n[gi]),
        .gpio_in(gpio_in[gi])
      );
    end
  endgenerate

endmodule
`default_nettype wire

// file: bench/hpp_chk_assertions.sv
`include "hpp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
// Pin checker driven by a shadow of the register writes
module hpp_chk
  import hpp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [15:0] pad_in,
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe_n
);
  logic wr_q;
  logic [7:0] a_q;
  hpp_ctrl_s c_q;
  logic [15:0] en_q;
  logic [15:0] dir_q;
  logic [15:0] out_q;
  logic [1:0] qt_q;
  wire take = hsel & htrans[1] & hready;
  // Shadow registers; quiet count lets registered pins catch up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      a_q <= 8'h00;
      c_q <= '0;
      en_q <= 16'h0000;
      dir_q <= 16'h0000;
      out_q <= 16'h0000;
      qt_q <= 2'h3;
    end else begin
      wr_q <= take & hwrite;
      a_q <= haddr[7:0];
      qt_q <= wr_q ? 2'h0 : qt_q + 2'(qt_q != 2'h3);
      if (wr_q && a_q == `HPP_OFF_CTRL) c_q <= hwdata[11:0];
      if (wr_q && a_q == `HPP_OFF_GPIO_EN) en_q <= hwdata[15:0];
      if (wr_q && a_q == `HPP_OFF_GPIO_DIR) dir_q <= hwdata[15:0];
      if (wr_q && a_q == `HPP_OFF_GPIO_OUT) out_q <= hwdata[15:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence gp_q;
    !c_q.host_fn && qt_q == 2'h3;
  endsequence
  sequence hq;
    c_q.host_fn && qt_q == 2'h3;
  endsequence
  sequence rd_at(logic [7:0] a);
    take && !hwrite && haddr[7:0] == a;
  endsequence
  chk_reset_pins: assert property ($rose(hresetn) |->
    pad_oe_n == 16'hffff && pad_out == 16'h0000) else $error("reset pins");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  chk_unmapped_zero: assert property (take && !hwrite &&
    haddr[7:0] > `HPP_OFF_STATUS |=> hrdata == 32'h0) else $error("unmapped");
  chk_ctrl_readback: assert property (rd_at(`HPP_OFF_CTRL) |=>
    hrdata == {20'h0, $past(c_q)}) else $error("ctrl readback");
  chk_gpio_dir: assert property (gp_q |->
    pad_oe_n == ~(en_q & dir_q)) else $error("gpio enable");
  chk_gpio_value: assert property (gp_q |->
    ((pad_out ^ out_q) & en_q & dir_q) == 16'h0) else $error("gpio value");
  chk_host_inputs: assert property (hq |-> &pad_oe_n[13:8] &&
    (c_q.dbl_req || pad_oe_n[15])) else $error("host input driven");
  chk_req_driven: assert property (hq ##0 !c_q.open_drain |->
    !pad_oe_n[14] && (!c_q.dbl_req || !pad_oe_n[15])) else $error("req");
  chk_open_drain: assert property (hq ##0 c_q.open_drain |->
    (pad_oe_n[14] || !pad_out[14]) && (pad_oe_n[15] || !pad_out[15]))
    else $error("open drain high");
endmodule
`default_nettype wire

// file: bench/hpp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// External host: drives its pins, device output wins on the wire
module hpp_host_model
  import hpp_pkg::*;
(
  input wire logic hclk,
  input wire logic [15:0] h_val,
  input wire logic [15:0] h_en,
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe_n,
  output logic [15:0] pad_in
);
  logic [15:0] flt_q = 16'h5a5a;
  // Released lines wander so a stale level is never trusted
  always_ff @(posedge hclk) flt_q <= ~flt_q;
  // Request pins carry pull-ups for open-drain use
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (h_en[i]) pad_in[i] = h_val[i];
      else if (i >= 14) pad_in[i] = 1'b1;
      else pad_in[i] = flt_q[i];
    end
  end
endmodule
`default_nettype wire

// file: bench/hpp_tb_top.sv
`include "hpp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("BAD %0t got %h exp %h", $time, g, e); \
    end \
  end
module hpp_tb_top;
  import hpp_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] h_val = 16'h0;
  logic [15:0] h_en = 16'h0;
  logic [31:0] hrdata;
  logic [31:0] d;
  logic hreadyout;
  logic hresp;
  logic [15:0] pad_in;
  logic [15:0] pad_out;
  logic [15:0] pad_oe_n;
  int cmp_count = 0;
  int fail_count = 0;
  // 125 MHz bus clock
  initial begin
    forever #4 hclk = ~hclk;
  end
  hpp_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n));
  hpp_host_model host_u (.hclk(hclk), .h_val(h_val), .h_en(h_en),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_in(pad_in));
  task automatic summarize;
    $display("cmp_count=%0d fail_count=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Bounded wait for hready; a hang ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= v;
    wait_rdy();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    haddr <= {24'h0, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    wait_rdy();
    v = hrdata;
  endtask
  // Host pins change just after an edge, held n cycles
  task automatic host(input logic [15:0] v, input logic [15:0] e,
                      input int n);
    h_val <= v;
    h_en <= e;
    repeat (n) @(posedge hclk);
  endtask
  task automatic s_reset;
    `CHK(pad_oe_n, 16'hffff)
    rd(`HPP_OFF_CTRL, d);
    `CHK(d, 32'h0)
  endtask
  // Pins 0-3 out, 4-7 in, rest disconnected
  task automatic s_gpio;
    wr(`HPP_OFF_GPIO_EN, 32'h00ff);
    wr(`HPP_OFF_GPIO_DIR, 32'h000f);
    wr(`HPP_OFF_GPIO_OUT, 32'h0005);
    host(16'h00a0, 16'h00f0, 3);
    `CHK(pad_oe_n, 16'hfff0)
    `CHK(pad_out[3:0], 4'h5)
    rd(`HPP_OFF_GPIO_IN, d);
    `CHK(d, 32'h00a0)
    rd(8'h20, d);
    `CHK(d, 32'h0)
  endtask
  // Plain bus, single strobe, all active low: host writes 0x3c
  task automatic s_hwrite;
    host(16'hb53c, 16'hbfff, 1);
    wr(`HPP_OFF_CTRL, 32'h1);
    // Let the GPIO drivers on pins 0-3 release before the strobe
    host(16'hb53c, 16'hbfff, 1);
    host(16'h853c, 16'hbfff, 3);
    host(16'hb53c, 16'hbfff, 4);
    `CHK(pad_oe_n[7:0], 8'hff)
    rd(`HPP_OFF_STATUS, d);
    `CHK(d, 32'h0502)
    rd(`HPP_OFF_RX_DATA, d);
    `CHK(d, 32'h3c)
    `CHK({pad_oe_n[14], pad_out[14]}, 2'b01)
  endtask
  // Host read returns the byte software queued
  task automatic s_hread;
    wr(`HPP_OFF_TX_DATA, 32'ha5);
    host(16'hbd00, 16'hbf00, 3);
    `CHK(pad_out[14], 1'b0)
    host(16'h8d00, 16'hbf00, 3);
    `CHK({pad_oe_n[7:0], pad_out[7:0]}, 16'h00a5)
    host(16'hbd00, 16'hbf00, 4);
    `CHK({pad_oe_n[7:0], pad_out[14]}, 9'h1ff)
    // Acknowledge alone, no select or strobe, reads the byte again
    host(16'h3d00, 16'hbf00, 3);
    `CHK({pad_oe_n[7:0], pad_out[7:0]}, 16'h00a5)
    host(16'hbd00, 16'hbf00, 3);
    `CHK(pad_oe_n[7:0], 8'hff)
  endtask
  // Multiplexed, double strobe and request, open drain, some high
  task automatic s_mux;
    host(16'h2a00, 16'h3fff, 1);
    wr(`HPP_OFF_CTRL, 32'h0a5f);
    host(16'h2b3c, 16'h3fff, 3);
    host(16'h2a5a, 16'h3fff, 1);
    host(16'h3a5a, 16'h3fff, 3);
    host(16'h2a5a, 16'h3fff, 4);
    `CHK({pad_oe_n[15:14], pad_out[15]}, 3'b010)
    rd(`HPP_OFF_STATUS, d);
    `CHK(d, 32'h0005_3c02)
    rd(`HPP_OFF_RX_DATA, d);
    `CHK(d, 32'h5a)
    repeat (3) @(posedge hclk);
    `CHK(pad_oe_n[15:14], 2'b11)
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_reset();
    s_gpio();
    s_hwrite();
    s_hread();
    s_mux();
    summarize();
  end
endmodule
bind hpp_top hpp_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe_n(pad_oe_n));
`default_nettype wire
